// File: core/adcrs_sequencer.sv
// Reference power sequencer for external serial clock conversion mode
//
// Contract
// - With an internal converter reference, the reference is switched off once the scan ends.
// - A conversion with an internal converter reference that finds it off waits 218 serial clocks first.
// - A temperature request turns the internal reference on and waits 244 serial clocks.
// - The temperature result is ready 188 serial clocks after settling; the host keeps clocking.
// - With an external converter reference, conversions leave the internal reference alone.
// - After reset the setting selects internal converter and external first reference pin.
// - Only the external clock mode is served; every delay is timed by the host serial clock.
`timescale 1ns/10ps
module adcrs_sequencer (
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic       sclk,
  input  wire logic       setupLoad,
  input  wire logic [1:0] referenceSelectIn,
  input  wire logic [1:0] clockModeSelectIn,
  input  wire logic       convRequest,
  input  wire logic       tempRequest,
  input  wire logic       scanDone,
  output logic            internalRefEnable,
  output logic            convertStart,
  output logic            tempResultReady,
  output logic            secondRefIsInput,
  output logic            busy,
  output logic [1:0]      referenceSelect,
  output logic [1:0]      clockModeSelect
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    adcrs_pkg::adcrs_state_t state;
    logic [1:0]              refSel;
    logic [1:0]              ckSel;
    logic                    refOn;
    logic                    startTgl;
    adcrs_pkg::adcrs_delay_t delaySel;
    logic                    doneSeen;
    logic                    convertStart;
    logic                    tempReady;
    logic                    secondRefAin;
  } adcrs_seq_t;

  localparam adcrs_seq_t SEQ_RESET = '{
    state:        adcrs_pkg::ADCRS_IDLE,
    refSel:       adcrs_pkg::REFSEL_DEFAULT,
    ckSel:        adcrs_pkg::CKSEL_RESET,
    refOn:        1'b0,
    startTgl:     1'b0,
    delaySel:     adcrs_pkg::ADCRS_DLY_WAKE,
    doneSeen:     1'b0,
    convertStart: 1'b0,
    tempReady:    1'b0,
    secondRefAin: 1'b1
  };

  adcrs_seq_t q;
  adcrs_seq_t d;
  logic       doneSync;
  logic       doneEvent;
  logic       extMode;
  logic       extRef;

  adcrs_link_if linkBus ();

  // ****************************************
  // Serial clock domain and crossing
  // ****************************************
  adcrs_link_timer uTimer (
    .sclk (sclk),
    .rst  (rst),
    .link (linkBus.link)
  );

  adcrs_sync2 uDoneSync (
    .clock   (clock),
    .rst     (rst),
    .asyncIn (linkBus.doneTgl),
    .syncOut (doneSync)
  );

  // Select and toggle held stable until the timer answers
  assign linkBus.startTgl = q.startTgl;
  assign linkBus.delaySel = q.delaySel;

  assign doneEvent = (doneSync != q.doneSeen);
  assign extMode   = (q.ckSel == adcrs_pkg::CKSEL_EXTERNAL);
  assign extRef    = adcrs_pkg::adcrs_is_ext_ref(q.refSel);

  // ****************************************
  // Sequencer
  // ****************************************
  always_comb begin
    d              = q;
    d.convertStart = 1'b0;
    d.tempReady    = 1'b0;
    d.doneSeen     = doneSync;
    case (q.state)
      adcrs_pkg::ADCRS_IDLE: begin
        if (setupLoad) begin
          d.refSel = referenceSelectIn;
          d.ckSel  = clockModeSelectIn;
        end else if (extMode && tempRequest) begin
          d.refOn    = 1'b1;
          d.delaySel = adcrs_pkg::ADCRS_DLY_SETTLE;
          d.startTgl = ~q.startTgl;
          d.state    = adcrs_pkg::ADCRS_TSETTLE;
        end else if (extMode && convRequest) begin
          if (extRef || q.refOn) begin
            d.convertStart = 1'b1;
            d.state        = adcrs_pkg::ADCRS_CONV;
          end else begin
            d.refOn    = 1'b1;
            d.delaySel = adcrs_pkg::ADCRS_DLY_WAKE;
            d.startTgl = ~q.startTgl;
            d.state    = adcrs_pkg::ADCRS_WAKE;
          end
        end
      end
      adcrs_pkg::ADCRS_WAKE: begin
        if (doneEvent) begin
          d.convertStart = 1'b1;
          d.state        = adcrs_pkg::ADCRS_CONV;
        end
      end
      adcrs_pkg::ADCRS_CONV: begin
        if (scanDone) begin
          if (!extRef) begin
            d.refOn = 1'b0;
          end
          d.state = adcrs_pkg::ADCRS_IDLE;
        end
      end
      adcrs_pkg::ADCRS_TSETTLE: begin
        if (doneEvent) begin
          d.delaySel = adcrs_pkg::ADCRS_DLY_TOUT;
          d.startTgl = ~q.startTgl;
          d.state    = adcrs_pkg::ADCRS_TOUT;
        end
      end
      adcrs_pkg::ADCRS_TOUT: begin
        if (doneEvent) begin
          d.tempReady = 1'b1;
          d.refOn     = 1'b0;
          d.state     = adcrs_pkg::ADCRS_IDLE;
        end
      end
      default: begin
        d.state = adcrs_pkg::ADCRS_IDLE;
      end
    endcase
    d.secondRefAin = !adcrs_pkg::adcrs_is_ext_ref(d.refSel);
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      q <= SEQ_RESET;
    end else begin
      q <= d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign internalRefEnable = q.refOn;
  assign convertStart      = q.convertStart;
  assign tempResultReady   = q.tempReady;
  assign secondRefIsInput  = q.secondRefAin;
  assign busy              = (q.state != adcrs_pkg::ADCRS_IDLE);
  assign referenceSelect   = q.refSel;
  assign clockModeSelect   = q.ckSel;

  // ****************************************
  // Checks
  // ****************************************
  sequence sTempTaken;
    q.state == adcrs_pkg::ADCRS_IDLE && !setupLoad && extMode && tempRequest;
  endsequence

  sequence sSettleEnd;
    q.state == adcrs_pkg::ADCRS_TSETTLE && doneEvent;
  endsequence

  sequence sOutEnd;
    q.state == adcrs_pkg::ADCRS_TOUT && doneEvent;
  endsequence

  sequence sConvTaken;
    q.state == adcrs_pkg::ADCRS_IDLE && !setupLoad && extMode && !tempRequest
      && convRequest;
  endsequence

  sequence sWakeEnd;
    q.state == adcrs_pkg::ADCRS_WAKE && doneEvent;
  endsequence

  sequence sScanEnd;
    q.state == adcrs_pkg::ADCRS_CONV && scanDone;
  endsequence

  sequence sBusyRequest;
    busy && (setupLoad || convRequest || tempRequest);
  endsequence

  AST_REF_OFF_AFTER_SCAN: assert property (@(posedge clock) disable iff (rst)
    (q.state == adcrs_pkg::ADCRS_CONV && scanDone && !extRef)
    |=> (!internalRefEnable && !busy))
    else $error("Internal reference stayed on after scan");

  AST_WAKE_BEFORE_CONV: assert property (@(posedge clock) disable iff (rst)
    (sConvTaken and (!extRef && !q.refOn))
    |=> (q.state == adcrs_pkg::ADCRS_WAKE && !convertStart && internalRefEnable
         && q.delaySel == adcrs_pkg::ADCRS_DLY_WAKE && q.startTgl != $past(q.startTgl)))
    else $error("Wake delay not started before conversion");

  AST_WAKE_HOLDS: assert property (@(posedge clock) disable iff (rst)
    (q.state == adcrs_pkg::ADCRS_WAKE && !doneEvent) |=> !convertStart)
    else $error("Conversion started during wake delay");

  AST_TEMP_SETTLE: assert property (@(posedge clock) disable iff (rst)
    sTempTaken |=> (q.state == adcrs_pkg::ADCRS_TSETTLE && internalRefEnable
                    && q.delaySel == adcrs_pkg::ADCRS_DLY_SETTLE))
    else $error("Temperature request did not start settling");

  AST_TEMP_OUT_CHAIN: assert property (@(posedge clock) disable iff (rst)
    sSettleEnd |=> (q.state == adcrs_pkg::ADCRS_TOUT
                    && q.delaySel == adcrs_pkg::ADCRS_DLY_TOUT && !tempResultReady))
    else $error("Result delay did not follow settling");

  AST_TEMP_READY: assert property (@(posedge clock) disable iff (rst)
    sOutEnd |=> (tempResultReady && !busy) ##1 !tempResultReady)
    else $error("Temperature result not flagged for one cycle");

  AST_EXT_REF_UNTOUCHED: assert property (@(posedge clock) disable iff (rst)
    (sConvTaken and extRef)
    |=> (convertStart && internalRefEnable == $past(internalRefEnable)
         && q.startTgl == $past(q.startTgl)))
    else $error("External reference conversion touched internal reference");

  AST_DEFAULT_SETTING: assert property (@(posedge clock)
    rst |=> (referenceSelect == adcrs_pkg::REFSEL_DEFAULT && !internalRefEnable
             && secondRefIsInput))
    else $error("Reset setting is not the default reference mode");

  AST_INTERNAL_MODE_IDLE: assert property (@(posedge clock) disable iff (rst)
    (q.state == adcrs_pkg::ADCRS_IDLE && !extMode && !setupLoad)
    |=> (!busy && !convertStart))
    else $error("Request served outside external clock mode");

  AST_SECOND_REF_ROLE: assert property (@(posedge clock) disable iff (rst)
    (setupLoad && q.state == adcrs_pkg::ADCRS_IDLE)
    |=> secondRefIsInput == !adcrs_pkg::adcrs_is_ext_ref($past(referenceSelectIn)))
    else $error("Second reference pin role does not follow setting");

  AST_WAKE_END: assert property (@(posedge clock) disable iff (rst)
    sWakeEnd |=> (convertStart && internalRefEnable
                  && q.state == adcrs_pkg::ADCRS_CONV))
    else $error("Conversion did not start after wake delay");

  AST_CONV_ONE_CYCLE: assert property (@(posedge clock) disable iff (rst)
    convertStart |=> !convertStart)
    else $error("Conversion start lasted more than one cycle");

  AST_CONV_REF_READY: assert property (@(posedge clock) disable iff (rst)
    (q.state == adcrs_pkg::ADCRS_CONV && !extRef)
    |-> internalRefEnable)
    else $error("Internal reference off during internal reference conversion");

  AST_NO_WAKE_EXT: assert property (@(posedge clock) disable iff (rst)
    (q.state == adcrs_pkg::ADCRS_WAKE) |-> !extRef)
    else $error("Wake delay run under external reference");

  AST_EXT_SCAN_END: assert property (@(posedge clock) disable iff (rst)
    (sScanEnd and extRef)
    |=> (!busy && internalRefEnable == $past(internalRefEnable)))
    else $error("External reference scan end touched internal reference");

  AST_TEMP_REF_HELD: assert property (@(posedge clock) disable iff (rst)
    (q.state == adcrs_pkg::ADCRS_TSETTLE || q.state == adcrs_pkg::ADCRS_TOUT)
    |-> internalRefEnable)
    else $error("Internal reference off during temperature delays");

  AST_SETTLE_HOLD: assert property (@(posedge clock) disable iff (rst)
    (q.state == adcrs_pkg::ADCRS_TSETTLE && !doneEvent)
    |=> (q.state == adcrs_pkg::ADCRS_TSETTLE && !tempResultReady))
    else $error("Settling delay left early");

  AST_TOUT_HOLD: assert property (@(posedge clock) disable iff (rst)
    (q.state == adcrs_pkg::ADCRS_TOUT && !doneEvent)
    |=> (q.state == adcrs_pkg::ADCRS_TOUT && !tempResultReady))
    else $error("Temperature result flagged before its delay ended");

  AST_READY_AFTER_OUT: assert property (@(posedge clock) disable iff (rst)
    tempResultReady |-> ($past(q.state) == adcrs_pkg::ADCRS_TOUT))
    else $error("Temperature result flagged outside the result delay");

  AST_SETUP_APPLIED: assert property (@(posedge clock) disable iff (rst)
    (setupLoad && q.state == adcrs_pkg::ADCRS_IDLE)
    |=> (referenceSelect == $past(referenceSelectIn)
         && clockModeSelect == $past(clockModeSelectIn)))
    else $error("Setting not taken in idle");

  AST_BUSY_REFUSES: assert property (@(posedge clock) disable iff (rst)
    sBusyRequest |=> ($stable(referenceSelect) && $stable(clockModeSelect)
                      && $stable(secondRefIsInput)))
    else $error("Request while busy changed the setting");

endmodule

// File: core/adcrs_pkg.sv
// Shared constants, types and helpers of the reference sequencer
package adcrs_pkg;

  // ****************************************
  // Reference and clock mode codes
  // ****************************************
  localparam logic [1:0] REFSEL_INT_BOTH  = 2'h0;
  localparam logic [1:0] REFSEL_EXT_SE    = 2'h1;
  localparam logic [1:0] REFSEL_INT_ADC   = 2'h2;
  localparam logic [1:0] REFSEL_EXT_DIFF  = 2'h3;
  localparam logic [1:0] REFSEL_DEFAULT   = REFSEL_INT_ADC;
  localparam logic [1:0] CKSEL_EXTERNAL   = 2'h3;
  localparam logic [1:0] CKSEL_RESET      = 2'h3;

  // ****************************************
  // Delays in serial clock cycles
  // ****************************************
  localparam int         CNT_W            = 8;
  localparam int         WAKE_SCLK        = 218;
  localparam int         SETTLE_SCLK      = 244;
  localparam int         TEMP_OUT_SCLK    = 188;
  localparam int         SCLK_MAX_KHZ     = 3600;

  typedef enum logic [1:0] {
    ADCRS_DLY_WAKE   = 2'h0,
    ADCRS_DLY_SETTLE = 2'h1,
    ADCRS_DLY_TOUT   = 2'h2
  } adcrs_delay_t;

  typedef enum logic [4:0] {
    ADCRS_IDLE    = 5'h01,
    ADCRS_WAKE    = 5'h02,
    ADCRS_CONV    = 5'h04,
    ADCRS_TSETTLE = 5'h08,
    ADCRS_TOUT    = 5'h10
  } adcrs_state_t;

  // True when the converter takes its reference from outside
  function automatic logic adcrs_is_ext_ref(input logic [1:0] sel);
    adcrs_is_ext_ref = (sel == REFSEL_EXT_SE) || (sel == REFSEL_EXT_DIFF);
  endfunction

  // Load value of the link down-counter, one less than the delay
  function automatic logic [CNT_W-1:0] adcrs_delay_load(input adcrs_delay_t sel);
    case (sel)
      ADCRS_DLY_WAKE:   adcrs_delay_load = CNT_W'(WAKE_SCLK - 1);
      ADCRS_DLY_SETTLE: adcrs_delay_load = CNT_W'(SETTLE_SCLK - 1);
      default:          adcrs_delay_load = CNT_W'(TEMP_OUT_SCLK - 1);
    endcase
  endfunction

endpackage

// File: core/adcrs_link_if.sv
// Request and completion signals between the system side and the link timer
`timescale 1ns/10ps
interface adcrs_link_if;
  logic                  startTgl;
  adcrs_pkg::adcrs_delay_t delaySel;
  logic                  doneTgl;

  modport sys  (output startTgl, output delaySel, input doneTgl);
  modport link (input startTgl, input delaySel, output doneTgl);
endinterface

// File: core/adcrs_sync2.sv
// Two flip-flop level synchroniser
`timescale 1ns/10ps
module adcrs_sync2 (
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic asyncIn,
  output logic      syncOut
);

  typedef struct packed {
    logic meta;
    logic stable;
  } adcrs_sync_t;

  adcrs_sync_t q;
  adcrs_sync_t d;

  always_comb begin
    d.meta   = asyncIn;
    d.stable = q.meta;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign syncOut = q.stable;

endmodule

// File: core/adcrs_link_timer.sv
// Delay counter clocked by the host serial clock
`timescale 1ns/10ps
module adcrs_link_timer (
  input  wire logic   sclk,
  input  wire logic   rst,
  adcrs_link_if.link  link
);

  typedef struct packed {
    logic                      ack;
    logic                      done;
    logic                      busy;
    logic [adcrs_pkg::CNT_W-1:0] cnt;
  } adcrs_timer_t;

  adcrs_timer_t q;
  adcrs_timer_t d;
  logic         linkRst;
  logic         startSync;

  adcrs_sync2 uRstSync (
    .clock   (sclk),
    .rst     (1'b0),
    .asyncIn (rst),
    .syncOut (linkRst)
  );

  adcrs_sync2 uStartSync (
    .clock   (sclk),
    .rst     (linkRst),
    .asyncIn (link.startTgl),
    .syncOut (startSync)
  );

  // ****************************************
  // Count serial clock edges
  // ****************************************
  always_comb begin
    d = q;
    if (!q.busy && (startSync != q.ack)) begin
      d.busy = 1'b1;
      d.ack  = startSync;
      d.cnt  = adcrs_pkg::adcrs_delay_load(link.delaySel);
    end else if (q.busy) begin
      if (q.cnt == '0) begin
        d.busy = 1'b0;
        d.done = ~q.done;
      end else begin
        d.cnt = q.cnt - 1'b1;
      end
    end
  end

  always_ff @(posedge sclk) begin
    if (linkRst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign link.doneTgl = q.done;

  AST_TIMER_END: assert property (@(posedge sclk) disable iff (linkRst)
    (q.busy && q.cnt == '0) |=> (!q.busy && q.done != $past(q.done)))
    else $error("Timer did not signal completion at zero");

  AST_TIMER_WAKE_LOAD: assert property (@(posedge sclk) disable iff (linkRst)
    ($rose(q.busy) && link.delaySel == adcrs_pkg::ADCRS_DLY_WAKE)
    |-> int'(q.cnt) == adcrs_pkg::WAKE_SCLK - 1)
    else $error("Wake delay not loaded with 218 cycles");

endmodule

// File: verification/adcrs_host_model.sv
// Serial host model that supplies the conversion clock
`timescale 1ns/10ps
module adcrs_host_model #(
  parameter realtime HALF_NS  = 40.0,
  parameter realtime PHASE_NS = 13.0
) (
  output logic sclk
);
  // ****************************************
  // Serial clock
  // ****************************************
  // Runs without pause, also through reset and every delay
  initial begin
    sclk = 1'b0;
    #(PHASE_NS);
    forever #(HALF_NS) sclk = ~sclk;
  end
endmodule

// File: verification/adcrs_sequencer_tb.sv
// Self-checking testbench of the reference sequencer
`timescale 1ns/10ps
module adcrs_sequencer_tb;
  localparam int SLACK   = 6;
  localparam int TIMEOUT = 90000;
  logic       clock;
  logic       rst;
  logic       sclk;
  logic       setupLoad;
  logic [1:0] refSelIn;
  logic [1:0] modeSelIn;
  logic       convRequest;
  logic       tempRequest;
  logic       scanDone;
  logic       internalRefEnable;
  logic       convertStart;
  logic       tempResultReady;
  logic       secondRefIsInput;
  logic       busy;
  logic [1:0] referenceSelect;
  logic [1:0] clockModeSelect;
  int         err_total;
  int         n_compared;
  int         sclkCount;
  int         cycleCount;

  adcrs_host_model u_adcrs_host_model (.sclk(sclk));

  adcrs_sequencer u_adcrs_sequencer (
    .clock             (clock),
    .rst               (rst),
    .sclk              (sclk),
    .setupLoad         (setupLoad),
    .referenceSelectIn (refSelIn),
    .clockModeSelectIn (modeSelIn),
    .convRequest       (convRequest),
    .tempRequest       (tempRequest),
    .scanDone          (scanDone),
    .internalRefEnable (internalRefEnable),
    .convertStart      (convertStart),
    .tempResultReady   (tempResultReady),
    .secondRefIsInput  (secondRefIsInput),
    .busy              (busy),
    .referenceSelect   (referenceSelect),
    .clockModeSelect   (clockModeSelect)
  );

  // ****************************************
  // Clocks, counters and hang guard
  // ****************************************
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  always @(posedge sclk) begin
    sclkCount <= sclkCount + 1;
  end

  always @(posedge clock) begin
    cycleCount <= cycleCount + 1;
    if (cycleCount == TIMEOUT) begin
      err_total++;
      close_out();
    end
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic ok, input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic pulse(ref logic sig);
    @(negedge clock);
    sig = 1'b1;
    @(negedge clock);
    sig = 1'b0;
  endtask

  task automatic load(input logic [1:0] r, input logic [1:0] m);
    @(negedge clock);
    refSelIn = r;
    modeSelIn = m;
    setupLoad = 1'b1;
    @(negedge clock);
    setupLoad = 1'b0;
    @(negedge clock);
    chk(referenceSelect === r, 16'(referenceSelect), 16'(r));
    chk(clockModeSelect === m, 16'(clockModeSelect), 16'(m));
  endtask

  // Counts serial clocks until the chosen pulse, then checks it lasts one cycle
  task automatic wait_pulse(input logic sel, output int n);
    int s;
    int k;
    s = sclkCount;
    k = 0;
    while ((sel ? tempResultReady : convertStart) !== 1'b1 && k < 12000) begin
      @(negedge clock);
      k++;
    end
    chk(k < 12000, 16'(k), 16'h0000);
    n = sclkCount - s;
    @(negedge clock);
    chk((sel ? tempResultReady : convertStart) === 1'b0, 16'h0001, 16'h0000);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic conv_scn(input logic [1:0] code);
    int n;
    load(code, 2'h3);
    chk(secondRefIsInput === ~code[0], 16'(secondRefIsInput), 16'(~code[0]));
    pulse(convRequest);
    wait_pulse(1'b0, n);
    if (code[0]) begin
      chk(n <= 1, 16'(n), 16'h0000);
      chk(internalRefEnable === 1'b0, 16'(internalRefEnable), 16'h0000);
    end else begin
      chk(n >= adcrs_pkg::WAKE_SCLK && n <= adcrs_pkg::WAKE_SCLK + SLACK, 16'(n),
          16'(adcrs_pkg::WAKE_SCLK));
      chk(internalRefEnable === 1'b1, 16'(internalRefEnable), 16'h0001);
    end
    pulse(scanDone);
    @(negedge clock);
    chk(internalRefEnable === 1'b0, 16'(internalRefEnable), 16'h0000);
    chk(busy === 1'b0, 16'(busy), 16'h0000);
  endtask

  task automatic temp_scn(input logic [1:0] code);
    int n;
    int e;
    e = adcrs_pkg::SETTLE_SCLK + adcrs_pkg::TEMP_OUT_SCLK;
    load(code, 2'h3);
    pulse(tempRequest);
    chk(internalRefEnable === 1'b1, 16'(internalRefEnable), 16'h0001);
    chk(busy === 1'b1, 16'(busy), 16'h0001);
    pulse(convRequest);
    wait_pulse(1'b1, n);
    chk(n >= e - 1 && n <= e + 2 * SLACK, 16'(n), 16'(e));
    chk(internalRefEnable === 1'b0, 16'(internalRefEnable), 16'h0000);
    chk(busy === 1'b0, 16'(busy), 16'h0000);
  endtask

  task automatic refuse_scn();
    load(2'h2, 2'h0);
    pulse(convRequest);
    repeat (8) @(negedge clock);
    chk(busy === 1'b0, 16'(busy), 16'h0000);
    chk(internalRefEnable === 1'b0, 16'(internalRefEnable), 16'h0000);
    load(2'h2, 2'h3);
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    rst = 1'b1;
    setupLoad = 1'b0;
    refSelIn = 2'h2;
    modeSelIn = 2'h3;
    convRequest = 1'b0;
    tempRequest = 1'b0;
    scanDone = 1'b0;
    // Reset must also span several serial clock edges
    repeat (100) @(negedge clock);
    chk(referenceSelect === adcrs_pkg::REFSEL_INT_ADC, 16'(referenceSelect), 16'h0002);
    chk(clockModeSelect === 2'h3, 16'(clockModeSelect), 16'h0003);
    chk(internalRefEnable === 1'b0, 16'(internalRefEnable), 16'h0000);
    chk(secondRefIsInput === 1'b1, 16'(secondRefIsInput), 16'h0001);
    rst = 1'b0;
    conv_scn(2'h2);
    conv_scn(2'h0);
    conv_scn(2'h1);
    conv_scn(2'h3);
    for (int c = 0; c < 4; c++) begin
      temp_scn(2'(c));
    end
    refuse_scn();
    close_out();
  end
endmodule
